// *** rtl/low_power_mode_control.sv ***
// low-power mode controller: enters doze, wait or stop on the stop
// instruction, gates clocks per mode, and returns to run on wakeup
// assumes core, interrupt controller and peripherals share this clock
`timescale 1ns/100ps
module low_power_mode_control
  import low_power_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            stopInstruction,    // one-cycle strobe from core
  input  wire power_mode_t     powerModeSelect,    // mode field
  input  wire logic            stopModeEnable,     // stop permitted
  input  wire logic [2:0]      exitPriorityThreshold,
  input  wire irq_req_t        irqReq,
  input  wire periph_events_t  events,
  input  wire periph_enables_t enables,
  output power_mode_t          currentMode,
  output clock_gates_t         clockGates,
  output logic                 coreIdle,          // core held with no cycles
  output logic                 systemClockHold,   // system clock held low
  output logic                 periphWakeIrq,     // peripheral interrupt to controller
  output logic                 wakePulse,         // one cycle when run restored
  output logic                 i2cFrozen,
  output logic                 timerFrozen
);

  // whole module state
  typedef struct packed {
    power_mode_t  mode;
    clock_gates_t gates;
    logic         idle;
    logic         clkHold;
    logic         irqOut;
    logic         wake;
    logic         i2cFreeze;
    logic         timerFreeze;
  } state_t;

  state_t stateReg;   // registered state
  state_t stateNext;  // next state
  logic   wakeOk;     // qualified interrupt wake
  logic   periphIrq;  // combined peripheral interrupt
  logic   dmaIrq;
  logic   i2cIrq;
  logic   timerIrq;
  logic   lowPower;

  // priority, mask and enable qualification
  wake_qualifier u_wake_qualifier (
    .irq                   (irqReq),
    .exitPriorityThreshold (exitPriorityThreshold),
    .wakeOk                (wakeOk)
  );

  // peripheral interrupt sources, each gated by its enable
  always_comb
  begin
    dmaIrq = enables.timer_dma_request_enable && events.dmaIrqEnable
             && (events.dmaDone || events.dmaConfigErr
                 || events.sourceBusError || events.destBusError);
    i2cIrq = enables.i2cEn && events.i2cUnitEnable
             && events.i2cIrqEnable && events.i2cIrqFlag;
    timerIrq = enables.timerEn && !events.timerDmaRequestEnable
               && ((events.timerCaptureModeNz && events.timerCapture)
                   || (events.referenceIrqEnable && events.timerRefReached));
    // chip select contributes nothing; it cannot wake
    periphIrq = dmaIrq || i2cIrq || timerIrq
                || (enables.watchdogEn && events.watchdogIrq)
                || (enables.uartEn && events.uartIrq)
                || (enables.serialEn && events.serialIrq);
  end

  assign lowPower = (stateReg.mode != MODE_RUN);

  // mode sequencing and clock gating
  always_comb
  begin
    stateNext      = stateReg;
    stateNext.wake = 1'b0;
    unique case (stateReg.mode)
      MODE_RUN:
      begin
        if (stopInstruction)
        begin
          // stop needs its enable; otherwise stay in run
          if (powerModeSelect == MODE_STOP && stopModeEnable)
            stateNext.mode = MODE_STOP;
          else if (powerModeSelect == MODE_WAIT || powerModeSelect == MODE_DOZE)
            stateNext.mode = powerModeSelect;
        end
      end
      MODE_DOZE, MODE_WAIT, MODE_STOP:
      begin
        // qualified interrupt returns to run at once, no recovery wait
        if (lowPower && wakeOk)
        begin
          stateNext.mode = MODE_RUN;
          stateNext.wake = 1'b1;
        end
      end
    endcase

    // per-mode gating; a cleared software enable wins, except while reset loads all gates on
    stateNext.gates.core       = (stateNext.mode == MODE_RUN);
    stateNext.gates.sram       = (stateNext.mode == MODE_RUN);
    stateNext.gates.watchdog   = enables.watchdogEn
                                 && (stateNext.mode != MODE_STOP);
    stateNext.gates.sdram      = enables.sdramEn
                                 && (stateNext.mode != MODE_STOP);
    stateNext.gates.chipSelect = enables.chipSelectEn
                                 && (stateNext.mode != MODE_STOP);
    stateNext.gates.dma        = enables.timer_dma_request_enable && (stateNext.mode != MODE_STOP);
    stateNext.gates.uart       = enables.uartEn && (stateNext.mode != MODE_STOP);
    stateNext.gates.serial     = enables.serialEn
                                 && (stateNext.mode != MODE_STOP);
    stateNext.gates.i2c        = enables.i2cEn && (stateNext.mode != MODE_STOP);
    stateNext.gates.timer      = enables.timerEn && (stateNext.mode != MODE_STOP);
    // wait and doze keep peripheral clocks stop gates all
    stateNext.idle        = (stateNext.mode != MODE_RUN);
    stateNext.clkHold     = (stateNext.mode == MODE_STOP);
    // freezes hold state; reset clears them so resume never follows reset
    stateNext.i2cFreeze   = (stateNext.mode == MODE_STOP);
    stateNext.timerFreeze = (stateNext.mode == MODE_STOP);
    // no peripheral interrupt from frozen peripherals in stop
    stateNext.irqOut      = periphIrq && (stateNext.mode != MODE_STOP);
  end

  // state register; any reset returns to run with clocks on
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stateReg             <= '0;
      stateReg.mode        <= MODE_RUN;
      stateReg.gates       <= '1;
    end
    else
      stateReg <= stateNext;
  end

  // outputs straight from state
  assign currentMode     = stateReg.mode;
  assign clockGates      = stateReg.gates;
  assign coreIdle        = stateReg.idle;
  assign systemClockHold = stateReg.clkHold;
  assign periphWakeIrq   = stateReg.irqOut;
  assign wakePulse       = stateReg.wake;
  assign i2cFrozen       = stateReg.i2cFreeze;
  assign timerFrozen     = stateReg.timerFreeze;

endmodule : low_power_mode_control

// *** rtl/low_power_pkg.sv ***
// low-power mode controller constants, types and carriers
// assumes a single system clock domain and synchronous active-high reset
//
// Operation
// - stop instruction enters selected low-power mode
// - mode field: 00 run 01 doze 10 wait 11 stop
// - idle core, gate clocks, stop holds clock low
// - reset or valid interrupt returns to run
// - wake level must exceed exit threshold
// - threshold 000 any, 11x only level 7
// - wake level exceeds core mask, unmasked, enabled
// - wait stops only core and memory clocks
// - doze stops core, peripherals follow own doze (here doze gates the same clocks as wait)
// - stop gates all clocks, peripherals keep state
// - software-disabled peripheral stays disabled in low power
// - core and static memory off, no recovery delay
// - watchdog wakes wait/doze, halted in stop
// - sdram runs in wait/doze, unclocked in stop
// - chip select runs in wait/doze, no wake
// - dma done or errors wake wait/doze only
// - uarts, serial wake wait/doze, freeze in stop
// - i2c interrupts on flag when enabled, not stop
// - i2c freezes in stop, resumes unless reset
// - timer capture/reference interrupt wakes wait/doze
// - timers halt in stop, resume unless reset
package low_power_pkg;

  // power mode select encodings
  typedef enum logic [1:0] {
    MODE_RUN  = 2'h0,
    MODE_DOZE = 2'h1,
    MODE_WAIT = 2'h2,
    MODE_STOP = 2'h3
  } power_mode_t;

  localparam int          LEVEL_W   = 3;            // interrupt level width
  localparam logic [2:0]  LEVEL_MAX = 3'h7;         // highest level
  localparam logic [2:0]  THRESH_ANY = 3'h0;        // threshold accepting any request
  localparam logic [2:0]  THRESH_TOP = 3'h6;        // 11x accept only top level

  // peripheral wake sources
  typedef struct packed {
    logic       watchdogIrq;   // core watchdog interrupt
    logic       dmaDone;       // dma transfer done
    logic       dmaConfigErr;  // dma configuration error
    logic       sourceBusError;
    logic       destBusError;
    logic       dmaIrqEnable;  // channel interrupt enable
    logic       uartIrq;       // any uart interrupt
    logic       serialIrq;     // queued serial interrupt
    logic       i2cUnitEnable;
    logic       i2cIrqEnable;
    logic       i2cIrqFlag;
    logic       timerCapture;  // capture event
    logic       timerCaptureModeNz;
    logic       timerRefReached;
    logic       referenceIrqEnable;
    logic       timerDmaRequestEnable;
  } periph_events_t;

  // peripheral software enables
  typedef struct packed {
    logic watchdogEn;
    logic sdramEn;
    logic chipSelectEn;
    logic timer_dma_request_enable;
    logic uartEn;
    logic serialEn;
    logic i2cEn;
    logic timerEn;
  } periph_enables_t;

  // clock gates per domain, high means running
  typedef struct packed {
    logic core;
    logic sram;
    logic watchdog;
    logic sdram;
    logic chipSelect;
    logic dma;
    logic uart;
    logic serial;
    logic i2c;
    logic timer;
  } clock_gates_t;

  // request from interrupt controller
  typedef struct packed {
    logic               valid;
    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] coreMask;
    logic               unmasked;
    logic               sourceEnabled;
  } irq_req_t;

endpackage : low_power_pkg

// *** rtl/wake_qualifier.sv ***
// wake qualifier: decides whether a pending interrupt may end low power
// assumes all inputs are synchronous to the system clock
`timescale 1ns/100ps
module wake_qualifier
  import low_power_pkg::*;
(
  input  wire irq_req_t   irq,
  input  wire logic [2:0] exitPriorityThreshold,
  output logic            wakeOk
);

  logic aboveThreshold;  // level beats exit threshold
  logic aboveMask;       // level beats core mask

  // threshold compare; 11x collapses to top level only
  always_comb
  begin
    if (exitPriorityThreshold == THRESH_ANY)
      aboveThreshold = 1'b1;
    else if (exitPriorityThreshold >= THRESH_TOP)
      aboveThreshold = (irq.level == LEVEL_MAX);
    else
      aboveThreshold = (irq.level > exitPriorityThreshold);
    aboveMask = (irq.level > irq.coreMask);
    wakeOk = irq.valid && aboveThreshold && aboveMask
             && irq.unmasked && irq.sourceEnabled;
  end

endmodule : wake_qualifier

// *** verif/core_model.sv ***
// processor core model: stop instruction and interrupt requests
// assumes it drives on the rising edge of the shared clock
`timescale 1ns/100ps
module core_model
  import low_power_pkg::*;
(
  input  wire logic   clock,
  output power_mode_t powerModeSelect,
  output logic        stopModeEnable,
  output logic        stopInstruction,
  output irq_req_t    irqReq
);
  initial
  begin
    powerModeSelect = MODE_RUN;
    stopModeEnable  = 1'b0;
    stopInstruction = 1'b0;
    irqReq          = '0;
  end
  // mode field and stop enable are written one edge ahead of the instruction
  task stop_cmd(input power_mode_t m, input logic en);
    @(posedge clock);
    powerModeSelect <= m;
    stopModeEnable  <= en;
    @(posedge clock);
    stopInstruction <= 1'b1;
    @(posedge clock);
    stopInstruction <= 1'b0;
  endtask : stop_cmd
  // one-cycle request; released fields show inverted values
  task raise(input logic [2:0] lv, input logic [2:0] msk, input logic um, input logic se);
    @(posedge clock);
    irqReq <= {1'b1, lv, msk, um, se};
    @(posedge clock);
    irqReq <= {1'b0, ~lv, ~msk, ~um, ~se};
  endtask : raise
endmodule : core_model

// *** verif/low_power_mode_control_properties.sv ***
// checker for the low-power mode controller top-level ports
// assumes one system clock and synchronous active-high reset
`timescale 1ns/100ps
module low_power_mode_control_properties
  import low_power_pkg::*;
(
  input wire logic            clock,
  input wire logic            rst,
  input wire logic            stopInstruction,
  input wire power_mode_t     powerModeSelect,
  input wire logic            stopModeEnable,
  input wire logic [2:0]      exitPriorityThreshold,
  input wire irq_req_t        irqReq,
  input wire periph_events_t  events,
  input wire periph_enables_t enables,
  input wire power_mode_t     currentMode,
  input wire clock_gates_t    clockGates,
  input wire logic            coreIdle,
  input wire logic            systemClockHold,
  input wire logic            periphWakeIrq,
  input wire logic            wakePulse,
  input wire logic            i2cFrozen,
  input wire logic            timerFrozen
);
  logic q;  // request that may end low power
  logic lp; // any low-power mode
  assign lp = currentMode != MODE_RUN;
  assign q = irqReq.valid && irqReq.unmasked && irqReq.sourceEnabled
    && irqReq.level > irqReq.coreMask && (exitPriorityThreshold == 3'h0
    || (exitPriorityThreshold[2:1] == 2'h3 ? irqReq.level == 3'h7
    : irqReq.level > exitPriorityThreshold));
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  entry_mode_a: assert property (!lp && stopInstruction && powerModeSelect != MODE_RUN
    && (powerModeSelect != MODE_STOP || stopModeEnable)
    |=> currentMode == $past(powerModeSelect) && coreIdle) else $error("entry wrong");
  stop_refused_a: assert property (!lp && stopInstruction && !stopModeEnable
    && powerModeSelect == MODE_STOP |=> !lp) else $error("stop not refused");
  idle_gates_a: assert property (lp |-> coreIdle
    && !clockGates.core && !clockGates.sram) else $error("core not gated");
  stop_freeze_a: assert property (currentMode == MODE_STOP |-> systemClockHold
    && i2cFrozen && timerFrozen && !clockGates.sdram) else $error("stop wrong");
  wake_run_a: assert property (lp && q |=> !lp && wakePulse
    && clockGates.core && !coreIdle) else $error("no wake");
  hold_mode_a: assert property (!rst && lp && !q |=> $stable(currentMode))
    else $error("left low power");
  pulse_once_a: assert property (wakePulse |=> !wakePulse) else $error("long pulse");
  run_clear_a: assert property (!lp |-> !systemClockHold
    && !i2cFrozen && !timerFrozen) else $error("frozen in run");
  wait_sdram_a: assert property (currentMode == MODE_WAIT && $past(enables.sdramEn)
    |-> clockGates.sdram) else $error("sdram gated");
endmodule : low_power_mode_control_properties

bind low_power_mode_control low_power_mode_control_properties props (.clock, .rst,
  .stopInstruction, .powerModeSelect, .stopModeEnable, .exitPriorityThreshold, .irqReq,
  .events, .enables, .currentMode, .clockGates, .coreIdle, .systemClockHold,
  .periphWakeIrq, .wakePulse, .i2cFrozen, .timerFrozen);

// *** verif/low_power_mode_control_tb.sv ***
// self-checking bench for the low-power mode controller
// assumes core_model drives the core side of the block
`timescale 1ns/100ps
module low_power_mode_control_tb;
  import low_power_pkg::*;
  logic clock = 1'b0, rst = 1'b1, stopInstruction, stopModeEnable, coreIdle, wakePulse;
  logic systemClockHold, periphWakeIrq, i2cFrozen, timerFrozen;
  logic [2:0] exitPriorityThreshold = 3'h0;
  periph_events_t events = '0;
  periph_enables_t enables = 8'hF7; // uart disabled by software
  power_mode_t powerModeSelect, currentMode;
  irq_req_t irqReq;
  clock_gates_t clockGates;
  int n_errors = 0, n_checks = 0;
  // first seven sources must interrupt, last three must not (timer dma request, dma irq not enabled, uart disabled)
  logic [15:0] evt [10] = '{16'h4400, 16'h00E0, 16'h1400, 16'h0018, 16'h0006, 16'h8000,
                            16'h0100, 16'h0019, 16'h4000, 16'h0200};
  always #5 clock = ~clock;
  core_model cm (.clock, .powerModeSelect, .stopModeEnable, .stopInstruction, .irqReq);
  low_power_mode_control dut (.clock, .rst, .stopInstruction, .powerModeSelect,
    .stopModeEnable, .exitPriorityThreshold, .irqReq, .events, .enables, .currentMode,
    .clockGates, .coreIdle, .systemClockHold, .periphWakeIrq, .wakePulse, .i2cFrozen,
    .timerFrozen);
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wake(input logic [2:0] lv, input logic [2:0] msk, input logic um, input logic se,
            input logic exp);
    cm.raise(lv, msk, um, se);
    #1;
    chk(currentMode == MODE_RUN, exp);
    chk(wakePulse, exp);
  endtask : wake
  task t_modes;
    for (int i = 1; i < 4; i++)
    begin
      cm.stop_cmd(power_mode_t'(i), 1'b1);
      #1;
      chk(currentMode, 10'(i));
      chk({coreIdle, clockGates.core, clockGates.sram, clockGates.uart}, 4'h8);
      chk({systemClockHold, i2cFrozen, timerFrozen}, {3{i == 3}});
      wake(3'h7, 3'h0, 1'b1, 1'b1, 1'b1);
    end
    cm.stop_cmd(MODE_STOP, 1'b0);
    #1 chk(currentMode, MODE_RUN);
    $display("modes done");
  endtask : t_modes
  task t_wake;
    logic [2:0] lo;
    for (int t = 1; t < 8; t++)
    begin
      @(posedge clock) exitPriorityThreshold <= 3'(t);
      lo = (t >= 6) ? 3'h7 : 3'(t + 1);
      cm.stop_cmd(MODE_WAIT, 1'b1);
      wake(lo - 3'h1, 3'h0, 1'b1, 1'b1, 1'b0);
      wake(lo, 3'h0, 1'b1, 1'b1, 1'b1);
    end
    @(posedge clock) exitPriorityThreshold <= 3'h0;
    cm.stop_cmd(MODE_DOZE, 1'b1);
    wake(3'h3, 3'h3, 1'b1, 1'b1, 1'b0);
    wake(3'h4, 3'h3, 1'b0, 1'b1, 1'b0);
    wake(3'h4, 3'h3, 1'b1, 1'b0, 1'b0);
    wake(3'h1, 3'h0, 1'b1, 1'b1, 1'b1);
    $display("wake done");
  endtask : t_wake
  task t_periph;
    cm.stop_cmd(MODE_WAIT, 1'b1);
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clock) events <= evt[k];
      repeat (2) @(posedge clock);
      #1 chk(periphWakeIrq, k < 7);
    end
    wake(3'h7, 3'h0, 1'b1, 1'b1, 1'b1);
    @(posedge clock) events <= evt[0];
    cm.stop_cmd(MODE_STOP, 1'b1);
    #1 chk({periphWakeIrq, clockGates.dma, clockGates.sdram}, 3'h0);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    #1 chk({currentMode, i2cFrozen, timerFrozen}, 4'h0);
    $display("periph done");
  endtask : t_periph
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_modes();
    t_wake();
    t_periph();
    results();
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule : low_power_mode_control_tb
